// file: rcal_defs.vh
// Constants for the calendar date register block
`ifndef RCAL_DEFS_VH
`define RCAL_DEFS_VH

// Clock rate and time base
`define RCAL_CLOCK_KHZ 100000
`define RCAL_HALF_SEC_MS 500
`define RCAL_HALF_SEC_CYCLES (`RCAL_HALF_SEC_MS * `RCAL_CLOCK_KHZ)
`define RCAL_DIV_W 32

// AHB-Lite
`define RCAL_ADDR_W 8
`define RCAL_HTRANS_NONSEQ 2'h2
`define RCAL_HRESP_OKAY 1'h0

// Register byte offsets
`define RCAL_OFS_YEAR 8'h00
`define RCAL_OFS_MONTH_DAY_VALUE 8'h04
`define RCAL_OFS_TIME 8'h08
`define RCAL_OFS_WEEKDAY 8'h0C
`define RCAL_OFS_CONTROL 8'h10
`define RCAL_OFS_ALARM 8'h14

// Year register fields
`define RCAL_YR_TENS_HI 7
`define RCAL_YR_TENS_LO 4
`define RCAL_YR_UNITS_HI 3
`define RCAL_YR_UNITS_LO 0

// Month/day register fields
`define RCAL_MON_TENS_BIT 12
`define RCAL_MON_UNITS_HI 11
`define RCAL_MON_UNITS_LO 8
`define RCAL_DAY_TENS_HI 5
`define RCAL_DAY_TENS_LO 4
`define RCAL_DAY_UNITS_HI 3
`define RCAL_DAY_UNITS_LO 0

// Time register fields
`define RCAL_TIME_HALF_BIT 24
`define RCAL_TIME_HOUR_HI 23
`define RCAL_TIME_HOUR_LO 16
`define RCAL_TIME_MIN_HI 15
`define RCAL_TIME_MIN_LO 8
`define RCAL_TIME_SEC_HI 7
`define RCAL_TIME_SEC_LO 0

// Control register bits
`define RCAL_CTL_UNLOCK_BIT 0
`define RCAL_CTL_OUT_EN_BIT 1
`define RCAL_CTL_OUT_SEL_BIT 2
`define RCAL_CTL_ALARM_EN_BIT 3

// Alarm register fields
`define RCAL_ALM_HOUR_HI 15
`define RCAL_ALM_HOUR_LO 8
`define RCAL_ALM_MIN_HI 7
`define RCAL_ALM_MIN_LO 0

// BCD limits
`define RCAL_BCD_NINE 4'h9
`define RCAL_MON_TENS_MAX 4'h1
`define RCAL_DAY_TENS_MAX 4'h3
`define RCAL_SEC_TOP_TENS 4'h5
`define RCAL_SEC_TOP_UNITS 4'h9
`define RCAL_HOUR_TOP_TENS 4'h2
`define RCAL_HOUR_TOP_UNITS 4'h3

// Reset date 2000-01-01, a Saturday (Sunday = 0)
`define RCAL_RST_YEAR_TENS 4'h0
`define RCAL_RST_YEAR_UNITS 4'h0
`define RCAL_RST_MON_TENS 1'h0
`define RCAL_RST_MON_UNITS 4'h1
`define RCAL_RST_DAY_TENS 2'h0
`define RCAL_RST_DAY_UNITS 4'h1
`define RCAL_RST_WEEKDAY 3'h6
`define RCAL_EPOCH_WEEKDAY 6
`define RCAL_WEEK_DAYS 7

`endif

// file: rcal_bcd_counter.v
// Two-digit BCD counter with load, wrapping to zero after a top value
`timescale 1ns/1ps
`include "rcal_defs.vh"
module rcal_bcd_counter #(
  parameter [3:0] TOP_TENS = 4'h5,
  parameter [3:0] TOP_UNITS = 4'h9
) (
  input wire i_clock,
  input wire i_reset,
  input wire i_inc,
  input wire i_load,
  input wire [7:0] i_load_value,
  output reg [7:0] o_value,
  output wire o_wrap
);
  wire at_top;

  assign at_top = (o_value[7:4] == TOP_TENS) && (o_value[3:0] == TOP_UNITS);
  assign o_wrap = i_inc && at_top;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_value <= 8'h00;
    end else if (i_load) begin
      // A software load wins over a count in the same cycle
      o_value <= i_load_value;
    end else if (i_inc) begin
      if (at_top) begin
        o_value <= 8'h00;
      end else if (o_value[3:0] == `RCAL_BCD_NINE) begin
        o_value <= {o_value[7:4] + 4'h1, 4'h0};
      end else begin
        o_value <= {o_value[7:4], o_value[3:0] + 4'h1};
      end
    end
  end
endmodule

// file: rcal_top.v
// Calendar and time-of-day counters with an AHB-Lite register slave
// the year advances.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "rcal_defs.vh"
module rcal_top #(
  parameter [31:0] HALF_SEC_CYCLES = `RCAL_HALF_SEC_CYCLES
) (
  input wire i_clock,
  input wire i_reset,
  input wire i_master_clear_n,
  input wire i_hsel,
  input wire [`RCAL_ADDR_W-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  output reg o_calendar_output
);
  // Synchroniser, bus and software register state
  reg master_clear_pin_meta_reg;
  reg master_clear_pin_sync_reg;
  wire master_clear_pin_active;
  reg wr_pend_reg;
  reg [`RCAL_ADDR_W-1:0] wr_addr_reg;
  wire addr_take, rd_take;
  reg [31:0] rd_next;
  reg [3:0] control_reg;
  reg [15:0] alarm_reg;
  wire calendar_write_unlock;

  // Calendar and time state
  reg [3:0] year_tens_digit;
  reg [3:0] year_units_digit;
  reg month_tens_digit;
  reg [3:0] month_units_digit;
  reg [1:0] date_tens_digit;
  reg [3:0] date_units_digit;
  reg [2:0] weekday_reg;
  reg [2:0] weekday_next;
  reg [`RCAL_DIV_W-1:0] div_reg;
  reg half_tick_reg;
  reg half_reg;
  wire sec_inc;
  wire [7:0] sec_value, min_value, hour_value;
  wire sec_wrap, min_wrap, day_wrap;

  // Write decodes and binary views of the date
  wire wr_year, wr_month_day_value, wr_time, wr_control, wr_alarm;
  wire year_ok, month_day_value_ok, time_ok;
  wire [6:0] year_bin;
  wire [3:0] month_bin;
  wire [5:0] day_bin;
  wire leap_year, last_day, alarm_match;
  reg [5:0] month_days;
  reg [8:0] days_before_month;
  reg [31:0] day_count, weekday_calc;

  assign master_clear_pin_active = ~master_clear_pin_sync_reg;
  assign calendar_write_unlock = control_reg[`RCAL_CTL_UNLOCK_BIT];

  // Second flop alone reads the first stage
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      master_clear_pin_meta_reg <= 1'b1;
      master_clear_pin_sync_reg <= 1'b1;
    end else begin
      master_clear_pin_meta_reg <= i_master_clear_n;
      master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY; hsize is ignored, whole-word access only
  assign addr_take = i_hsel && (i_htrans == `RCAL_HTRANS_NONSEQ) && i_hready;
  assign rd_take = addr_take && !i_hwrite;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {`RCAL_ADDR_W{1'b0}};
      o_hreadyout <= 1'b1;
      o_hresp <= `RCAL_HRESP_OKAY;
      o_hrdata <= 32'h00000000;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= `RCAL_HRESP_OKAY;
      wr_pend_reg <= addr_take && i_hwrite;
      if (addr_take) begin
        wr_addr_reg <= i_haddr;
      end
      if (rd_take) begin
        o_hrdata <= rd_next;
      end
    end
  end

  // Read data is sampled at the address phase so it can leave a flop in the data phase
  always @* begin
    rd_next = 32'h00000000;
    case (i_haddr)
      `RCAL_OFS_YEAR: begin
        rd_next[`RCAL_YR_TENS_HI:`RCAL_YR_TENS_LO] = year_tens_digit;
        rd_next[`RCAL_YR_UNITS_HI:`RCAL_YR_UNITS_LO] = year_units_digit;
      end
      `RCAL_OFS_MONTH_DAY_VALUE: begin
        rd_next[`RCAL_MON_TENS_BIT] = month_tens_digit;
        rd_next[`RCAL_MON_UNITS_HI:`RCAL_MON_UNITS_LO] = month_units_digit;
        rd_next[`RCAL_DAY_TENS_HI:`RCAL_DAY_TENS_LO] = date_tens_digit;
        rd_next[`RCAL_DAY_UNITS_HI:`RCAL_DAY_UNITS_LO] = date_units_digit;
      end
      `RCAL_OFS_TIME: begin
        rd_next[`RCAL_TIME_HALF_BIT] = half_reg;
        rd_next[`RCAL_TIME_HOUR_HI:`RCAL_TIME_HOUR_LO] = hour_value;
        rd_next[`RCAL_TIME_MIN_HI:`RCAL_TIME_MIN_LO] = min_value;
        rd_next[`RCAL_TIME_SEC_HI:`RCAL_TIME_SEC_LO] = sec_value;
      end
      `RCAL_OFS_WEEKDAY: rd_next[2:0] = weekday_reg;
      `RCAL_OFS_CONTROL: rd_next[3:0] = control_reg;
      `RCAL_OFS_ALARM: rd_next[15:0] = alarm_reg;
      default: rd_next = 32'h00000000;
    endcase
  end
  // Unlisted bits stay zero above: upper year byte and month/day gaps

  // Digit range checks; an out-of-range digit drops the whole write
  assign year_ok = (i_hwdata[`RCAL_YR_TENS_HI:`RCAL_YR_TENS_LO] <= `RCAL_BCD_NINE) &&
                   (i_hwdata[`RCAL_YR_UNITS_HI:`RCAL_YR_UNITS_LO] <= `RCAL_BCD_NINE);
  assign month_day_value_ok = (i_hwdata[`RCAL_MON_UNITS_HI:`RCAL_MON_UNITS_LO] <= `RCAL_BCD_NINE) &&
                    (i_hwdata[`RCAL_DAY_UNITS_HI:`RCAL_DAY_UNITS_LO] <= `RCAL_BCD_NINE);
  assign time_ok = (i_hwdata[`RCAL_TIME_SEC_LO+3:`RCAL_TIME_SEC_LO] <= `RCAL_BCD_NINE) &&
                   (i_hwdata[`RCAL_TIME_SEC_HI:`RCAL_TIME_SEC_LO+4] <= `RCAL_SEC_TOP_TENS) &&
                   (i_hwdata[`RCAL_TIME_MIN_LO+3:`RCAL_TIME_MIN_LO] <= `RCAL_BCD_NINE) &&
                   (i_hwdata[`RCAL_TIME_MIN_HI:`RCAL_TIME_MIN_LO+4] <= `RCAL_SEC_TOP_TENS) &&
                   (i_hwdata[`RCAL_TIME_HOUR_LO+3:`RCAL_TIME_HOUR_LO] <= `RCAL_BCD_NINE) &&
                   (i_hwdata[`RCAL_TIME_HOUR_HI:`RCAL_TIME_HOUR_LO+4] <= `RCAL_HOUR_TOP_TENS);

  assign wr_year = wr_pend_reg && (wr_addr_reg == `RCAL_OFS_YEAR) && calendar_write_unlock && year_ok;
  assign wr_month_day_value = wr_pend_reg && (wr_addr_reg == `RCAL_OFS_MONTH_DAY_VALUE) && calendar_write_unlock && month_day_value_ok;
  assign wr_time = wr_pend_reg && (wr_addr_reg == `RCAL_OFS_TIME) && calendar_write_unlock && time_ok;
  assign wr_control = wr_pend_reg && (wr_addr_reg == `RCAL_OFS_CONTROL);
  assign wr_alarm = wr_pend_reg && (wr_addr_reg == `RCAL_OFS_ALARM);

  // Control and alarm are bus-side state, so master clear resets them
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      control_reg <= 4'h0;
      alarm_reg <= 16'h0000;
    end else if (master_clear_pin_active) begin
      control_reg <= 4'h0;
      alarm_reg <= 16'h0000;
    end else begin
      if (wr_control) begin
        control_reg <= i_hwdata[3:0];
      end
      if (wr_alarm) begin
        alarm_reg <= i_hwdata[15:0];
      end
    end
  end

  // Half-second time base; master clear does not touch it
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= {`RCAL_DIV_W{1'b0}};
      half_tick_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (wr_time) begin
      // Restart the second so the loaded time holds for a full second
      div_reg <= {`RCAL_DIV_W{1'b0}};
      half_tick_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      half_tick_reg <= 1'b0;
      if (div_reg == HALF_SEC_CYCLES - 32'd1) begin
        div_reg <= {`RCAL_DIV_W{1'b0}};
        half_tick_reg <= 1'b1;
      end else begin
        div_reg <= div_reg + 32'd1;
      end
      if (half_tick_reg) begin
        half_reg <= ~half_reg;
      end
    end
  end

  // Seconds advance on every second half-second step
  assign sec_inc = half_tick_reg && half_reg;

  rcal_bcd_counter #(
    .TOP_TENS(`RCAL_SEC_TOP_TENS),
    .TOP_UNITS(`RCAL_SEC_TOP_UNITS)
  ) u_seconds (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_inc(sec_inc),
    .i_load(wr_time),
    .i_load_value(i_hwdata[`RCAL_TIME_SEC_HI:`RCAL_TIME_SEC_LO]),
    .o_value(sec_value),
    .o_wrap(sec_wrap)
  );

  rcal_bcd_counter #(
    .TOP_TENS(`RCAL_SEC_TOP_TENS),
    .TOP_UNITS(`RCAL_SEC_TOP_UNITS)
  ) u_minutes (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_inc(sec_wrap),
    .i_load(wr_time),
    .i_load_value(i_hwdata[`RCAL_TIME_MIN_HI:`RCAL_TIME_MIN_LO]),
    .o_value(min_value),
    .o_wrap(min_wrap)
  );

  rcal_bcd_counter #(
    .TOP_TENS(`RCAL_HOUR_TOP_TENS),
    .TOP_UNITS(`RCAL_HOUR_TOP_UNITS)
  ) u_hours (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_inc(min_wrap),
    .i_load(wr_time),
    .i_load_value(i_hwdata[`RCAL_TIME_HOUR_HI:`RCAL_TIME_HOUR_LO]),
    .o_value(hour_value),
    .o_wrap(day_wrap)
  );

  // Binary views of the BCD date
  assign year_bin = {3'h0, year_tens_digit} * 7'd10 + {3'h0, year_units_digit};
  assign month_bin = month_tens_digit ? (month_units_digit + 4'hA) : month_units_digit;
  assign day_bin = {4'h0, date_tens_digit} * 6'd10 + {2'h0, date_units_digit};
  // Every year divisible by four is leap within 2000-2099
  assign leap_year = (year_bin[1:0] == 2'b00);

  always @* begin
    case (month_bin)
      4'h2: month_days = leap_year ? 6'd29 : 6'd28;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 6'd30;
      default: month_days = 6'd31;
    endcase
  end

  assign last_day = (day_bin >= month_days);

  // Date registers; the day rolls over when the hour counter wraps
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      year_tens_digit <= `RCAL_RST_YEAR_TENS;
      year_units_digit <= `RCAL_RST_YEAR_UNITS;
      month_tens_digit <= `RCAL_RST_MON_TENS;
      month_units_digit <= `RCAL_RST_MON_UNITS;
      date_tens_digit <= `RCAL_RST_DAY_TENS;
      date_units_digit <= `RCAL_RST_DAY_UNITS;
    end else begin
      if (day_wrap) begin
        if (last_day) begin
          date_tens_digit <= `RCAL_RST_DAY_TENS;
          date_units_digit <= `RCAL_RST_DAY_UNITS;
          if (month_tens_digit && (month_units_digit == 4'h2)) begin
            month_tens_digit <= `RCAL_RST_MON_TENS;
            month_units_digit <= `RCAL_RST_MON_UNITS;
            // 2099 wraps back to 2000
            if (year_units_digit == `RCAL_BCD_NINE) begin
              year_units_digit <= 4'h0;
              year_tens_digit <= (year_tens_digit == `RCAL_BCD_NINE) ? 4'h0 : year_tens_digit + 4'h1;
            end else begin
              year_units_digit <= year_units_digit + 4'h1;
            end
          end else if (month_units_digit == `RCAL_BCD_NINE) begin
            month_tens_digit <= 1'b1;
            month_units_digit <= 4'h0;
          end else begin
            month_units_digit <= month_units_digit + 4'h1;
          end
        end else if (date_units_digit == `RCAL_BCD_NINE) begin
          date_tens_digit <= date_tens_digit + 2'h1;
          date_units_digit <= 4'h0;
        end else begin
          date_units_digit <= date_units_digit + 4'h1;
        end
      end
      // A software write lands after the rollover so it wins
      if (wr_year) begin
        year_tens_digit <= i_hwdata[`RCAL_YR_TENS_HI:`RCAL_YR_TENS_LO];
        year_units_digit <= i_hwdata[`RCAL_YR_UNITS_HI:`RCAL_YR_UNITS_LO];
      end
      if (wr_month_day_value) begin
        month_tens_digit <= i_hwdata[`RCAL_MON_TENS_BIT];
        month_units_digit <= i_hwdata[`RCAL_MON_UNITS_HI:`RCAL_MON_UNITS_LO];
        date_tens_digit <= i_hwdata[`RCAL_DAY_TENS_HI:`RCAL_DAY_TENS_LO];
        date_units_digit <= i_hwdata[`RCAL_DAY_UNITS_HI:`RCAL_DAY_UNITS_LO];
      end
    end
  end

  // Days of the current year before the current month, leap day not counted
  always @* begin
    case (month_bin)
      4'h2: days_before_month = 9'd31;
      4'h3: days_before_month = 9'd59;
      4'h4: days_before_month = 9'd90;
      4'h5: days_before_month = 9'd120;
      4'h6: days_before_month = 9'd151;
      4'h7: days_before_month = 9'd181;
      4'h8: days_before_month = 9'd212;
      4'h9: days_before_month = 9'd243;
      4'hA: days_before_month = 9'd273;
      4'hB: days_before_month = 9'd304;
      4'hC: days_before_month = 9'd334;
      default: days_before_month = 9'd0;
    endcase
  end

  // Weekday follows the stored date, so it is right after any date write
  always @* begin
    day_count = {25'h0, year_bin} * 32'd365 + ({25'h0, year_bin} + 32'd3) / 32'd4 +
                {23'h0, days_before_month} + {26'h0, day_bin} +
                ((leap_year && (month_bin > 4'h2)) ? 32'd1 : 32'd0);
    // Day one of the epoch counts as one, so the epoch weekday is offset by one
    weekday_calc = (day_count + `RCAL_EPOCH_WEEKDAY - 32'd1) % `RCAL_WEEK_DAYS;
    weekday_next = weekday_calc[2:0];
  end

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      weekday_reg <= `RCAL_RST_WEEKDAY;
    end else begin
      weekday_reg <= weekday_next;
    end
  end

  // Alarm matches on hours and minutes for the whole matching minute
  assign alarm_match = control_reg[`RCAL_CTL_ALARM_EN_BIT] &&
                       (hour_value == alarm_reg[`RCAL_ALM_HOUR_HI:`RCAL_ALM_HOUR_LO]) &&
                       (min_value == alarm_reg[`RCAL_ALM_MIN_HI:`RCAL_ALM_MIN_LO]);

  // Output pin: tick is high in the first half of each second
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_calendar_output <= 1'b0;
    end else if (!control_reg[`RCAL_CTL_OUT_EN_BIT]) begin
      o_calendar_output <= 1'b0;
    end else if (control_reg[`RCAL_CTL_OUT_SEL_BIT]) begin
      o_calendar_output <= ~half_reg;
    end else begin
      o_calendar_output <= alarm_match;
    end
  end
endmodule

// file: rcal_checker.sv
// Concurrent checks on the register bus side of the calendar block
`timescale 1ns/1ps
`include "rcal_defs.vh"
module rcal_checker #(
  parameter [31:0] HALF_SEC_CYCLES = `RCAL_HALF_SEC_CYCLES
) (
  input wire i_clock,
  input wire i_reset,
  input wire i_master_clear_n,
  input wire i_hsel,
  input wire [`RCAL_ADDR_W-1:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_calendar_output
);
  wire read_take;
  assign read_take = i_hsel && i_htrans == `RCAL_HTRANS_NONSEQ && i_hready && !i_hwrite;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  sequence s_read_at(logic [`RCAL_ADDR_W-1:0] addr);
    read_take && i_haddr == addr;
  endsequence
  a_ready_high: assert property (o_hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (o_hresp == `RCAL_HRESP_OKAY)
    else $error("response not OKAY");
  // Read data must not drift between reads, or a slow master takes a wrong word
  a_rdata_holds: assert property (!read_take |=> $stable(o_hrdata))
    else $error("read data changed without a read");
  a_year_upper: assert property (s_read_at(`RCAL_OFS_YEAR) |=> o_hrdata[31:8] == 24'h0)
    else $error("year upper bits not zero");
  a_year_digits: assert property (s_read_at(`RCAL_OFS_YEAR) |=> o_hrdata[7:4] <= `RCAL_BCD_NINE
    && o_hrdata[3:0] <= `RCAL_BCD_NINE)
    else $error("year digit out of range");
  a_month_day_value_zeros: assert property (s_read_at(`RCAL_OFS_MONTH_DAY_VALUE) |=> o_hrdata[31:13] == 19'h0
    && o_hrdata[7:6] == 2'h0)
    else $error("month/day unused bits not zero");
  a_month_day_value_digits: assert property (s_read_at(`RCAL_OFS_MONTH_DAY_VALUE) |=> o_hrdata[11:8] <= `RCAL_BCD_NINE
    && o_hrdata[3:0] <= `RCAL_BCD_NINE)
    else $error("month/day digit out of range");
  a_unmapped_zero: assert property (s_read_at(8'h20) |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind rcal_top rcal_checker #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_master_clear_n(i_master_clear_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_calendar_output(o_calendar_output));

// file: test_rtc_calendar_date_registers.sv
// Self-checking testbench for the calendar date register block
`timescale 1ns/1ps
`include "rcal_defs.vh"
module test_rtc_calendar_date_registers;
  // Short half-second so a whole second passes in a few cycles
  localparam [31:0] HALF = 32'h4;
  logic i_clock;
  logic i_reset;
  logic i_master_clear_n;
  logic i_hsel;
  logic i_hwrite;
  logic [`RCAL_ADDR_W-1:0] i_haddr;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic [31:0] i_hwdata;
  logic [31:0] rd;
  wire [31:0] o_hrdata;
  wire o_hreadyout;
  wire o_hresp;
  wire o_calendar_output;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  rcal_top #(.HALF_SEC_CYCLES(HALF)) dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_master_clear_n(i_master_clear_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_calendar_output(o_calendar_output));
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  task report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cuts a hung handshake short
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_ready();
    @(posedge i_clock);
    while (o_hreadyout !== 1'h1) @(posedge i_clock);
  endtask
  task xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    i_haddr <= addr;
    i_htrans <= `RCAL_HTRANS_NONSEQ;
    i_hwrite <= wr;
    wait_ready();
    i_htrans <= 2'h0;
    i_hwdata <= wdata;
    wait_ready();
    rd = o_hrdata;
  endtask
  task wr(input logic [7:0] addr, input logic [31:0] wdata);
    xfer(1'h1, addr, wdata);
  endtask
  task rdchk(input logic [7:0] addr, input logic [31:0] exp);
    xfer(1'h0, addr, 32'h0);
    check(rd, exp);
  endtask
  task t_reset_values();
    rdchk(`RCAL_OFS_YEAR, 32'h0);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h101);
    rdchk(`RCAL_OFS_WEEKDAY, 32'h6);
    wr(8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0);
  endtask
  task t_locked();
    wr(`RCAL_OFS_YEAR, 32'h99);
    rdchk(`RCAL_OFS_YEAR, 32'h0);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, 32'h1231);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h101);
  endtask
  task t_fields();
    wr(`RCAL_OFS_CONTROL, 32'h1);
    wr(`RCAL_OFS_YEAR, 32'hFFFFFF59);
    rdchk(`RCAL_OFS_YEAR, 32'h59);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, 32'hFFFFE9F9);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h939);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, 32'h1131);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h1131);
  endtask
  // Out-of-range digits are dropped whole, so the old value must survive
  task t_range();
    wr(`RCAL_OFS_YEAR, 32'h5A);
    rdchk(`RCAL_OFS_YEAR, 32'h59);
    wr(`RCAL_OFS_YEAR, 32'hA5);
    rdchk(`RCAL_OFS_YEAR, 32'h59);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, 32'h0A01);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h1131);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, 32'h010A);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, 32'h1131);
  endtask
  task t_roll(input logic [31:0] y, md, ey, emd, ewd, input logic mc);
    wr(`RCAL_OFS_CONTROL, 32'h1);
    wr(`RCAL_OFS_YEAR, y);
    wr(`RCAL_OFS_MONTH_DAY_VALUE, md);
    wr(`RCAL_OFS_TIME, 32'h235959);
    i_master_clear_n <= ~mc;
    repeat (4 * HALF + 4) @(posedge i_clock);
    i_master_clear_n <= 1'h1;
    rdchk(`RCAL_OFS_YEAR, ey);
    rdchk(`RCAL_OFS_MONTH_DAY_VALUE, emd);
    rdchk(`RCAL_OFS_WEEKDAY, ewd);
    rdchk(`RCAL_OFS_CONTROL, mc ? 32'h0 : 32'h1);
  endtask
  task t_output();
    int ones;
    wr(`RCAL_OFS_CONTROL, 32'h7);
    repeat (4) @(posedge i_clock);
    ones = 0;
    repeat (16) begin
      @(negedge i_clock);
      ones = ones + o_calendar_output;
    end
    @(posedge i_clock);
    check(ones, 32'h8);
    wr(`RCAL_OFS_ALARM, 32'h2359);
    wr(`RCAL_OFS_TIME, 32'h235900);
    wr(`RCAL_OFS_CONTROL, 32'hB);
    repeat (3) @(posedge i_clock);
    check(o_calendar_output, 32'h1);
    wr(`RCAL_OFS_CONTROL, 32'h3);
    repeat (3) @(posedge i_clock);
    check(o_calendar_output, 32'h0);
  endtask
  initial begin
    i_reset = 1'h1;
    i_master_clear_n = 1'h1;
    i_hsel = 1'h0;
    i_haddr = 8'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'h0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'h0;
    i_hsel <= 1'h1;
    t_reset_values();
    t_locked();
    t_fields();
    t_range();
    t_roll(32'h99, 32'h1231, 32'h0, 32'h101, 32'h6, 1'h0);
    t_roll(32'h24, 32'h228, 32'h24, 32'h229, 32'h4, 1'h1);
    t_roll(32'h23, 32'h228, 32'h23, 32'h301, 32'h3, 1'h0);
    t_roll(32'h24, 32'h131, 32'h24, 32'h201, 32'h4, 1'h0);
    t_output();
    report_and_stop();
  end
endmodule
